// [design/ecpm_mode_ctrl.sv]
// Extended-capability parallel port mode controller with AXI4-Lite register slave
//
// Summary of operation
// - Extended control bit 0 reads 1 when FIFO empty, else 0.
// - Mode 000 holds FIFO in reset, control lines open-collector, direction ignored.
// - Mode 001 direction tri-states data; data reads return live pins; push-pull.
// - Mode 010 sends FIFO bytes with compatibility handshake, forward only.
// - Mode 011 forward: data and command writes share one FIFO, sent via ECP.
// - Mode 011 reverse: peripheral bytes handshaken into the FIFO for host reads.
// - Mode 100 selects enhanced port only when option bit enabled; push-pull.
// - Mode 110 lets host write and read FIFO; nothing transmitted.
// - Mode 111 maps configuration A and B at 0x400 and 0x401.
// - Config B bits 5:3 encode the interrupt line per fixed table.
// - Config B bits 2:0 encode the DMA channel per fixed table.
// - Automatic handshaking runs only in modes 010 and 011, starting on entry.
// - Software drains FIFO first; device deasserts handshake outputs before switching back.
// - Leaving ECP reverse for mode 000 or 001 discards extra bytes and drops host acknowledge at once.
// - No glitches on handshake outputs across mode changes.
// - Command port bytes go as commands, data port bytes as data; commands forward only.
// - All FIFO transfers are exactly one byte wide.
// - Reverse direction keeps filling FIFO; host reads data port while not empty.
// - Mode field is bits 7:5 of extended control, readable and writable.
// - Forward host acknowledge high for data, low for commands.
`timescale 1ns/1ps
module ecpm_mode_ctrl (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clkEn,
   input wire logic [12:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [12:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] irqLineSel,
   input wire logic [1:0] dmaChanSel,
   input wire logic irqLevel,
   input wire logic [7:0] pdIn,
   output logic [7:0] pdOut,
   output logic pdOe,
   input wire logic busyIn,
   input wire logic peripAckLowIn,
   input wire logic faultLowIn,
   input wire logic selectIn,
   input wire logic perrorIn,
   output logic strobeOutLow,
   output logic hostAckOutLow,
   output logic initOutLow,
   output logic selectInOutLow,
   output logic ctlOe,
   output logic ctlPushPull,
   output logic eppActive
);
   import ecpm_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers: change counts once stages 2 and 3 agree
   // ----------------------------------------------------------------
   logic [13:0] syncA_ff, syncB_ff, syncC_ff, pinStable_ff;
   wire [13:0] rawPins = {irqLevel, pdIn, busyIn, peripAckLowIn, faultLowIn, selectIn, perrorIn};
   wire [13:0] nxt_pinStable;
   genvar gi;
   generate
      for (gi = 0; gi < 14; gi++) begin : g_sync
         assign nxt_pinStable[gi] = (syncB_ff[gi] == syncC_ff[gi]) ? syncC_ff[gi] : pinStable_ff[gi];
      end
   endgenerate
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         syncA_ff <= 14'h0000;
         syncB_ff <= 14'h0000;
         syncC_ff <= 14'h0000;
         pinStable_ff <= 14'h0000;
      end else if (clkEn) begin
         syncA_ff <= rawPins;
         syncB_ff <= syncA_ff;
         syncC_ff <= syncB_ff;
         pinStable_ff <= nxt_pinStable;
      end
   end
   wire [7:0] pdLive = pinStable_ff[12:5];
   wire busyS = pinStable_ff[4];
   wire peripAckLowS = pinStable_ff[3];
   wire [7:0] statusByte = {~busyS, peripAckLowS, pinStable_ff[0], pinStable_ff[1], pinStable_ff[2], 3'h0};

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] dataReg_ff, ctrlReg_ff, extReg_ff;
   logic eppOption_ff;
   logic [2:0] mode;
   assign mode = extReg_ff[7:5];
   wire dirIn = ctrlReg_ff[CTL_DIR_BIT] && (mode != MODE_STD) && (mode != MODE_FIFO);
   wire autoMode = (mode == MODE_FIFO) || (mode == MODE_ECP);

   // ----------------------------------------------------------------
   // Shared FIFO; bit 8 tags command bytes
   // ----------------------------------------------------------------
   logic [8:0] fifoMem [FIFO_DEPTH];
   logic [3:0] wrPtr_ff, rdPtr_ff;
   logic [4:0] count_ff;
   logic [7:0] lastRd_ff;
   wire fifoEmpty = (count_ff == 5'h00);
   wire fifoFull = (count_ff == FIFO_DEPTH_CNT);
   wire [8:0] fifoHead = fifoMem[rdPtr_ff];

   // ----------------------------------------------------------------
   // AXI4-Lite decode
   // ----------------------------------------------------------------
   logic [12:0] awAddr_ff;
   logic awHeld_ff, wHeld_ff;
   logic [31:0] wData_ff;
   logic [3:0] wStrb_ff;
   wire doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
   wire wrLane0 = wStrb_ff[0];
   wire [7:0] wByte = wData_ff[7:0];
   wire cfgMode = (mode == MODE_CFG);
   wire hostFifoMode = (mode == MODE_FIFO) || (mode == MODE_TEST) || (mode == MODE_ECP && !dirIn);
   wire wrData = doWrite && wrLane0 && awAddr_ff == ADDR_DATA;
   wire wrCtrl = doWrite && wrLane0 && awAddr_ff == ADDR_CONTROL;
   wire wrExt = doWrite && wrLane0 && awAddr_ff == ADDR_EXT_CTRL;
   wire wrOpt = doWrite && wrLane0 && awAddr_ff == ADDR_OPTION;
   // in config mode the FIFO port address is config A, read-only
   wire wrFifoData = doWrite && wrLane0 && awAddr_ff == ADDR_FIFO_CFGA && !cfgMode && hostFifoMode;
   wire wrFifoCmd = doWrite && wrLane0 && awAddr_ff == ADDR_CMD_PORT && mode == MODE_ECP && !dirIn;
   wire wrKnown = awAddr_ff == ADDR_DATA || awAddr_ff == ADDR_STATUS || awAddr_ff == ADDR_CONTROL
                  || awAddr_ff == ADDR_CMD_PORT || awAddr_ff == ADDR_OPTION || awAddr_ff == ADDR_FIFO_CFGA
                  || awAddr_ff == ADDR_CFGB || awAddr_ff == ADDR_EXT_CTRL;

   function automatic logic [2:0] irqCode(input logic [3:0] line);
      case (line)
         4'hF: irqCode = 3'h6;
         4'hE: irqCode = 3'h5;
         4'hB: irqCode = 3'h4;
         4'hA: irqCode = 3'h3;
         4'h9: irqCode = 3'h2;
         4'h7: irqCode = 3'h1;
         4'h5: irqCode = 3'h7;
         default: irqCode = 3'h0;
      endcase
   endfunction : irqCode

   wire [2:0] dmaCode = {1'b0, dmaChanSel};
   wire [7:0] cfgB = {1'b0, pinStable_ff[13], irqCode(irqLineSel), dmaCode};

   wire [7:0] extRead = {extReg_ff[7:2], fifoFull, fifoEmpty};
   wire rdFifoAddr = s_axi_araddr == ADDR_FIFO_CFGA;
   wire rdFifo = s_axi_arvalid && s_axi_arready && rdFifoAddr && !cfgMode
                 && (mode == MODE_TEST || (mode == MODE_ECP && dirIn));
   wire [7:0] rdByte =
      (s_axi_araddr == ADDR_DATA) ? ((mode == MODE_BIDIR) ? pdLive : dataReg_ff) :
      (s_axi_araddr == ADDR_STATUS) ? statusByte :
      (s_axi_araddr == ADDR_CONTROL) ? {2'h0, ctrlReg_ff[5:0]} :
      (s_axi_araddr == ADDR_OPTION) ? {7'h00, eppOption_ff} :
      (rdFifoAddr && cfgMode) ? CFGA_VALUE :
      (rdFifoAddr) ? (fifoEmpty ? lastRd_ff : fifoHead[7:0]) :
      (s_axi_araddr == ADDR_CFGB && cfgMode) ? cfgB :
      (s_axi_araddr == ADDR_EXT_CTRL) ? extRead : 8'h00;
   wire rdKnown = s_axi_araddr == ADDR_DATA || s_axi_araddr == ADDR_STATUS || s_axi_araddr == ADDR_CONTROL
                  || s_axi_araddr == ADDR_OPTION || rdFifoAddr || s_axi_araddr == ADDR_CFGB
                  || s_axi_araddr == ADDR_EXT_CTRL || s_axi_araddr == ADDR_CMD_PORT;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         awHeld_ff <= 1'b0;
         wHeld_ff <= 1'b0;
         awAddr_ff <= 13'h0000;
         wData_ff <= 32'h0000_0000;
         wStrb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= AXI_OKAY;
      end else if (clkEn) begin
         s_axi_awready <= !awHeld_ff && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !wHeld_ff && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrKnown ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rdByte};
            s_axi_rresp <= rdKnown ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         dataReg_ff <= 8'h00;
         ctrlReg_ff <= CTRL_RESET;
         extReg_ff <= EXT_RESET;
         eppOption_ff <= 1'b0;
      end else if (clkEn) begin
         if (wrData)
            dataReg_ff <= wByte;
         if (wrCtrl)
            ctrlReg_ff <= {2'h0, wByte[5:0]};
         if (wrExt)
            extReg_ff <= {wByte[7:2], 2'h0};
         if (wrOpt)
            eppOption_ff <= wByte[0];
      end
   end

   // ----------------------------------------------------------------
   // Handshake engine
   // ----------------------------------------------------------------
   ecpm_hs_e state_ff;
   logic [7:0] timer_ff;
   logic [7:0] txByte_ff;
   logic txCmd_ff;
   logic hsStrobe_ff, hsAck_ff;
   wire fwdRun = autoMode && !dirIn;
   wire revRun = mode == MODE_ECP && dirIn;
   wire popFwd = state_ff == ECPM_IDLE && fwdRun && !fifoEmpty;
   wire revCapture = state_ff == ECPM_REV_ACK && !hsAck_ff && revRun;
   wire timerDone = timer_ff == 8'h00;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_ff <= ECPM_IDLE;
         timer_ff <= 8'h00;
         txByte_ff <= 8'h00;
         txCmd_ff <= 1'b0;
         hsStrobe_ff <= 1'b0;
         hsAck_ff <= 1'b0;
      end else if (clkEn) begin
         if (!autoMode) begin
            // Abort any transfer; reverse bytes in flight are dropped
            state_ff <= ECPM_IDLE;
            hsStrobe_ff <= 1'b0;
            hsAck_ff <= 1'b0;
         end else begin
            if (timer_ff != 8'h00)
               timer_ff <= timer_ff - 8'h01;
            case (state_ff)
               ECPM_IDLE: begin
                  if (popFwd) begin
                     txByte_ff <= fifoHead[7:0];
                     txCmd_ff <= fifoHead[8];
                     timer_ff <= STROBE_CYC;
                     state_ff <= ECPM_SETUP;
                  end else if (revRun && !fifoFull && !peripAckLowS) begin
                     state_ff <= ECPM_REV_ACK;
                  end
               end
               ECPM_SETUP: begin
                  if (timerDone && !busyS) begin
                     hsStrobe_ff <= 1'b1;
                     timer_ff <= STROBE_CYC;
                     state_ff <= ECPM_STROBE;
                  end
               end
               ECPM_STROBE: begin
                  if (timerDone) begin
                     hsStrobe_ff <= 1'b0;
                     state_ff <= ECPM_WAITACK;
                  end
               end
               ECPM_WAITACK: begin
                  if (!busyS)
                     state_ff <= ECPM_IDLE;
               end
               ECPM_REV_ACK: begin
                  // Byte taken on entry; release waits for the peripheral to lift its ack
                  if (!hsAck_ff) begin
                     hsAck_ff <= 1'b1;
                  end else if (peripAckLowS) begin
                     hsAck_ff <= 1'b0;
                     state_ff <= ECPM_REV_REL;
                  end
               end
               ECPM_REV_REL: state_ff <= ECPM_IDLE;
               default: state_ff <= ECPM_IDLE;
            endcase
         end
      end
   end
   // ----------------------------------------------------------------
   // FIFO pointers; mode 000 holds it in reset
   // ----------------------------------------------------------------
   wire doPush = (wrFifoData || wrFifoCmd || revCapture) && !fifoFull;
   wire doPop = popFwd || (rdFifo && !fifoEmpty);
   wire [8:0] pushWord = revCapture ? {1'b0, pdLive} : {wrFifoCmd, wByte};
   always_ff @(posedge sys_clk) begin
      if (!resetn || (clkEn && (mode == MODE_STD || (mode == MODE_BIDIR && dirIn)))) begin
         wrPtr_ff <= 4'h0;
         rdPtr_ff <= 4'h0;
         count_ff <= 5'h00;
         lastRd_ff <= 8'h00;
      end else if (clkEn) begin
         if (doPush) begin
            fifoMem[wrPtr_ff] <= pushWord;
            wrPtr_ff <= wrPtr_ff + 4'h1;
         end
         if (doPop) begin
            rdPtr_ff <= rdPtr_ff + 4'h1;
            lastRd_ff <= fifoHead[7:0];
         end
         count_ff <= count_ff + {4'h0, doPush} - {4'h0, doPop};
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers, all registered to stay glitch free
   // ----------------------------------------------------------------
   wire hsOwn = autoMode && state_ff != ECPM_IDLE;
   wire nxtStrobeLow = autoMode ? !hsStrobe_ff : !ctrlReg_ff[0];
   // forward host ack high for data, low for commands
   wire nxtAckLow = (mode == MODE_ECP) ? (dirIn ? !hsAck_ff : !(hsOwn && txCmd_ff)) : !ctrlReg_ff[1];
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pdOut <= 8'h00;
         pdOe <= 1'b1;
         strobeOutLow <= 1'b1;
         hostAckOutLow <= 1'b1;
         initOutLow <= 1'b0;
         selectInOutLow <= 1'b1;
         ctlOe <= 1'b1;
         ctlPushPull <= 1'b0;
         eppActive <= 1'b0;
      end else if (clkEn) begin
         pdOut <= hsOwn ? txByte_ff : dataReg_ff;
         pdOe <= !dirIn;
         strobeOutLow <= nxtStrobeLow;
         hostAckOutLow <= nxtAckLow;
         initOutLow <= ctrlReg_ff[2];
         selectInOutLow <= !ctrlReg_ff[3];
         ctlPushPull <= mode != MODE_STD;
         // Any of the four lines pulled low needs the open-collector driver on
         ctlOe <= (mode != MODE_STD) || !(nxtStrobeLow && nxtAckLow && ctrlReg_ff[2] && !ctrlReg_ff[3]);
         eppActive <= mode == MODE_EPP && eppOption_ff;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_EMPTY_FLAG: assert property (@(posedge sys_clk) disable iff (!resetn) extRead[0] == (count_ff == 5'h00))
      else $error("empty flag disagrees with FIFO count");
   AST_STD_FIFO_RESET: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkEn && mode == MODE_STD) |=> count_ff == 5'h00)
      else $error("FIFO not held in reset in standard mode");
   AST_STD_DIR_OUT: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkEn && mode == MODE_STD) |=> pdOe)
      else $error("data drivers disabled in standard mode");
   AST_NO_AUTO_HS: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkEn && !autoMode) |=> state_ff == ECPM_IDLE && !hsStrobe_ff)
      else $error("handshake active outside auto modes");
   AST_TEST_NO_TX: assert property (@(posedge sys_clk) disable iff (!resetn)
      (mode == MODE_TEST) |-> !popFwd)
      else $error("test mode transmitted a byte");
   AST_REV_ACK_DROP: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkEn && $past(clkEn) && $past(revRun) && !revRun && !autoMode) |=> hostAckOutLow == !ctrlReg_ff[1])
      else $error("host ack not released on leaving reverse mode");
   AST_EPP_GATE: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkEn && !eppOption_ff) |=> !eppActive)
      else $error("enhanced mode active without option");
   AST_CMD_TAG: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkEn && wrFifoCmd && !fifoFull && !revCapture) |=> fifoMem[$past(wrPtr_ff)][8])
      else $error("command byte not tagged");
   AST_CFG_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkEn && s_axi_arvalid && s_axi_arready && rdFifoAddr && cfgMode) |=> s_axi_rdata[7:0] == CFGA_VALUE)
      else $error("config A not returned in config mode");
endmodule : ecpm_mode_ctrl

// [design/ecpm_pkg.sv]
// Package: register map, field positions, modes and timing constants for the ECP mode controller
package ecpm_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses (AXI4-Lite, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [12:0] ADDR_DATA = 13'h0000;
   localparam logic [12:0] ADDR_STATUS = 13'h0004;
   localparam logic [12:0] ADDR_CONTROL = 13'h0008;
   localparam logic [12:0] ADDR_CMD_PORT = 13'h000C;
   localparam logic [12:0] ADDR_OPTION = 13'h0010;
   // Index 0x400 and up times four needs 13 address bits
   localparam logic [12:0] IDX_FIFO_CFGA = 13'h0400;
   localparam logic [12:0] IDX_CFGB = 13'h0401;
   localparam logic [12:0] ADDR_FIFO_CFGA = IDX_FIFO_CFGA << 2;
   localparam logic [12:0] ADDR_CFGB = IDX_CFGB << 2;
   localparam logic [12:0] ADDR_EXT_CTRL = 13'h0402 << 2;
   // ----------------------------------------------------------------
   // Fields
   // ----------------------------------------------------------------
   localparam int EXT_MODE_LSB = 5;
   localparam int EXT_FULL_BIT = 1;
   localparam int EXT_EMPTY_BIT = 0;
   localparam int CTL_DIR_BIT = 5;
   localparam int CFGB_IRQ_LSB = 3;
   localparam logic [7:0] CFGA_VALUE = 8'h10;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] EXT_RESET = 8'h00;
   localparam logic [3:0] IRQ_RESET = 4'h0;
   localparam logic [1:0] DMA_RESET = 2'h0;
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] FIFO_DEPTH_CNT = 5'h10;
   // ----------------------------------------------------------------
   // Modes
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_STD = 3'h0;
   localparam logic [2:0] MODE_BIDIR = 3'h1;
   localparam logic [2:0] MODE_FIFO = 3'h2;
   localparam logic [2:0] MODE_ECP = 3'h3;
   localparam logic [2:0] MODE_EPP = 3'h4;
   localparam logic [2:0] MODE_TEST = 3'h6;
   localparam logic [2:0] MODE_CFG = 3'h7;
   // ----------------------------------------------------------------
   // Handshake timing
   // ----------------------------------------------------------------
   localparam int STROBE_NS = 500;
   localparam int CLK_MHZ = 200;
   localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   typedef enum logic [2:0] {ECPM_IDLE, ECPM_SETUP, ECPM_STROBE, ECPM_WAITACK, ECPM_REV_ACK, ECPM_REV_REL} ecpm_hs_e;
endpackage : ecpm_pkg

// [verif/ecpm_periph_model.sv]
// Peripheral model answering the forward strobe handshake
`timescale 1ns/1ps
module ecpm_periph_model (
   input wire logic sys_clk,
   input wire logic strobeOutLow,
   input wire logic hostAckOutLow,
   input wire logic [7:0] pdOut,
   input wire logic pdOe,
   output logic busyIn,
   output logic peripAckLowIn,
   output logic [7:0] pdIn
);
   logic [2:0] relCnt = 3'h0;
   logic [7:0] revByte = 8'hC3;
   // Released data lines carry the reverse byte, a value the host never drove
   assign pdIn = pdOe ? pdOut : revByte;
   always @(posedge sys_clk) begin
      if (!strobeOutLow) begin
         busyIn <= 1'b1;
         relCnt <= 3'h4;
      end else if (relCnt != 3'h0) begin
         relCnt <= relCnt - 3'h1;
         peripAckLowIn <= (relCnt != 3'h2);
         if (relCnt == 3'h1) busyIn <= 1'b0;
      end else if (!pdOe) begin
         // Reverse: offer a byte with ack low, step on once the host acknowledges
         busyIn <= 1'b0;
         if (peripAckLowIn && hostAckOutLow) begin
            peripAckLowIn <= 1'b0;
         end else if (!peripAckLowIn && !hostAckOutLow) begin
            peripAckLowIn <= 1'b1;
            revByte <= revByte + 8'h11;
         end
      end else begin
         busyIn <= 1'b0;
         peripAckLowIn <= 1'b1;
      end
   end
endmodule : ecpm_periph_model

// [verif/testbench.sv]
// Self-checking bench for the ECP mode controller
`timescale 1ns/1ps
module testbench;
   import ecpm_pkg::*;
   logic sys_clk = 0, resetn = 0, aw = 0, w = 0, b = 0, ar = 0, r = 0, awr, wr, bv, arr, rv, irqLevel = 0;
   logic [12:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd;
   logic [1:0] br, rr, dma = 0;
   logic [3:0] irq = 0;
   logic [7:0] pdIn, pdOut;
   logic busy, pack, pdOe, stb, hak, init, sel, ctlOe, pp, epp;
   int errors = 0, check_count = 0, cyc = 0;
   ecpm_mode_ctrl i_ecpm_mode_ctrl (.sys_clk(sys_clk), .resetn(resetn), .clkEn(1'b1), .s_axi_awaddr(awa),
      .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(w),
      .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(b), .s_axi_araddr(ara),
      .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(r), .irqLineSel(irq), .dmaChanSel(dma), .irqLevel(irqLevel), .pdIn(pdIn), .pdOut(pdOut),
      .pdOe(pdOe), .busyIn(busy), .peripAckLowIn(pack), .faultLowIn(1'b1), .selectIn(1'b1), .perrorIn(1'b0),
      .strobeOutLow(stb), .hostAckOutLow(hak), .initOutLow(init), .selectInOutLow(sel), .ctlOe(ctlOe),
      .ctlPushPull(pp), .eppActive(epp));
   ecpm_periph_model i_ecpm_periph_model (.sys_clk(sys_clk), .strobeOutLow(stb), .hostAckOutLow(hak),
      .pdOut(pdOut), .pdOe(pdOe),
      .busyIn(busy), .peripAckLowIn(pack), .pdIn(pdIn));
   initial forever #2.5 sys_clk = ~sys_clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr32(input logic [12:0] a, input logic [31:0] d);
      awa <= a; wd <= d; aw <= 1; w <= 1; b <= 1;
      forever begin
         @(posedge sys_clk);
         if (awr) aw <= 0;
         if (wr) w <= 0;
         if (bv) break;
      end
   endtask : wr32
   task automatic rd32(input logic [12:0] a, input logic [31:0] exp);
      ara <= a; ar <= 1; r <= 1;
      forever begin
         @(posedge sys_clk);
         if (arr) ar <= 0;
         if (rv) break;
      end
      chk(rd, exp);
   endtask : rd32
   task automatic mode(input logic [2:0] m);
      wr32(ADDR_EXT_CTRL, {24'h0, m, 5'h0});
   endtask : mode
   task automatic sent(input logic [7:0] d, input logic h);
      int n;
      for (n = 0; n < 3000 && stb !== 1'b0; n++) @(posedge sys_clk);
      chk({hak, pdOut}, {h, d});
      while (stb !== 1'b1) @(posedge sys_clk);
   endtask : sent
   task automatic t_test_fifo;
      rd32(ADDR_EXT_CTRL, 32'h01);
      mode(MODE_TEST);
      wr32(ADDR_FIFO_CFGA, 32'h44);
      wr32(ADDR_FIFO_CFGA, 32'h33);
      rd32(ADDR_EXT_CTRL, 32'hC0);
      rd32(ADDR_FIFO_CFGA, 32'h44);
      rd32(ADDR_FIFO_CFGA, 32'h33);
      rd32(ADDR_EXT_CTRL, 32'hC1);
      chk(stb, 1'b1);
      mode(MODE_STD);
   endtask : t_test_fifo
   function automatic logic [2:0] irqCode(input int i);
      case (i)
         15: return 3'h6; 14: return 3'h5; 11: return 3'h4; 10: return 3'h3;
         9: return 3'h2; 7: return 3'h1; 5: return 3'h7; default: return 3'h0;
      endcase
   endfunction : irqCode
   task automatic t_config;
      mode(MODE_CFG);
      rd32(ADDR_FIFO_CFGA, 32'h10);
      for (int i = 0; i < 16; i++) begin
         irq <= 4'(i); dma <= 2'(i); irqLevel <= i[0];
         repeat (5) @(posedge sys_clk);
         rd32(ADDR_CFGB, {24'h0, 1'b0, 1'(i), irqCode(i), 1'b0, 2'(i)});
      end
      rd32(13'h0FFC, 32'h0);
      chk(rr, AXI_SLVERR);
      mode(MODE_STD);
   endtask : t_config
   task automatic t_bidir;
      repeat (2) @(posedge sys_clk);
      chk({pp, ctlOe, init, sel}, 4'b0101);
      wr32(ADDR_CONTROL, 32'h04);
      repeat (2) @(posedge sys_clk);
      chk({ctlOe, init, sel}, 3'b011);
      mode(MODE_BIDIR);
      wr32(ADDR_CONTROL, 32'h2C);
      repeat (6) @(posedge sys_clk);
      chk({pp, pdOe, ctlOe, init, sel}, 5'b10110);
      rd32(ADDR_DATA, 32'hC3);
      wr32(ADDR_CONTROL, 32'h00);
      mode(MODE_STD);
   endtask : t_bidir
   task automatic t_forward;
      mode(MODE_FIFO);
      wr32(ADDR_FIFO_CFGA, 32'hA7);
      sent(8'hA7, 1'b1);
      mode(MODE_STD);
      mode(MODE_ECP);
      wr32(ADDR_CMD_PORT, 32'h85);
      wr32(ADDR_FIFO_CFGA, 32'h5A);
      sent(8'h85, 1'b0);
      sent(8'h5A, 1'b1);
      repeat (20) @(posedge sys_clk);
      rd32(ADDR_EXT_CTRL, 32'h61);
      mode(MODE_STD);
      chk({stb, hak}, 2'b11);
   endtask : t_forward
   task automatic t_reverse;
      mode(MODE_BIDIR);
      wr32(ADDR_CONTROL, 32'h20);
      mode(MODE_ECP);
      repeat (60) @(posedge sys_clk);
      rd32(ADDR_FIFO_CFGA, 32'hC3);
      rd32(ADDR_FIFO_CFGA, 32'hD4);
      rd32(ADDR_EXT_CTRL, 32'h60);
      mode(MODE_BIDIR);
      rd32(ADDR_EXT_CTRL, 32'h21);
      chk(hak, 1'b1);
      wr32(ADDR_CONTROL, 32'h00);
      mode(MODE_STD);
   endtask : t_reverse
   task automatic t_epp;
      mode(MODE_EPP);
      repeat (3) @(posedge sys_clk);
      chk({epp, pp}, 2'b01);
      mode(MODE_STD);
      wr32(ADDR_OPTION, 32'h1);
      mode(MODE_EPP);
      repeat (3) @(posedge sys_clk);
      chk(epp, 1'b1);
   endtask : t_epp
   task automatic stop_test;
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1;
      t_test_fifo();
      t_config();
      t_bidir();
      t_forward();
      t_reverse();
      t_epp();
      stop_test();
   end
endmodule : testbench
